// ### dv/tb.sv
`timescale 1ns/10ps
module tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic        se;
	logic [11:0] core_a_offset, core_b_offset;
	logic [4:0]  core_a_bank0_gain, core_a_bank1_gain;
	int          err_total = 0, checks = 0;
	converter_trim_registers converter_trim_registers_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_a_offset, .core_b_offset,
		.core_a_bank0_gain, .core_a_bank1_gain);
	// 50 ns half period gives 10 MHz
	always #50 pclk = ~pclk;
	task automatic end_of_test;
		if (err_total == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the wait is bounded so a silent slave still ends the run
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			end_of_test();
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk({2'b00, q}, {2'b00, e});
	endtask
	// Trim outputs settle one edge after the store
	task automatic outs(input logic [11:0] a, input logic [11:0] b, input logic [9:0] g);
		@(posedge pclk);
		#1;
		chk({core_a_offset, core_b_offset, core_a_bank0_gain, core_a_bank1_gain}, {a, b, g});
	endtask
	task automatic s_reset;
		outs(12'h000, 12'h000, 10'h000);
		rd(16'h0d20, 32'h0000_0000);
		rd(16'h0d44, 32'h0000_0000);
		chk({33'h0, se}, 34'h0);
	endtask
	// Reset in mid-run clears every stored trim
	task automatic s_rerun;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		outs(12'h000, 12'h000, 10'h000);
		rd(16'h0d40, 32'h0000_0000);
	endtask
	task automatic s_single;
		apb(1'b1, 16'h0d80, 32'h0000_0003);
		apb(1'b1, 16'h0d20, 32'h0000_f5a3);
		apb(1'b1, 16'h0d30, 32'h0000_0abc);
		outs(12'h5a3, 12'habc, 10'h000);
		rd(16'h0d20, 32'h0000_f5a3);
		apb(1'b1, 16'h0d80, 32'h0000_0007);
		apb(1'b1, 16'h0d28, 32'h0000_0123);
		apb(1'b1, 16'h0d38, 32'h0000_0fed);
		outs(12'h123, 12'hfed, 10'h000);
	endtask
	task automatic s_dual;
		apb(1'b1, 16'h0d80, 32'h0000_0001);
		apb(1'b1, 16'h0d40, 32'h0000_00ff);
		apb(1'b1, 16'h0d44, 32'h0000_000a);
		outs(12'h000, 12'habc, {5'h1f, 5'h0a});
		rd(16'h0d40, 32'h0000_00ff);
	endtask
	task automatic s_off;
		apb(1'b1, 16'h0d80, 32'h0000_0000);
		outs(12'h000, 12'h000, 10'h000);
		rd(16'h0d84, 32'h0000_0000);
		chk({33'h0, se}, 34'h1);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		s_reset();
		s_single();
		s_dual();
		s_rerun();
		s_off();
		end_of_test();
	end
endmodule

// ### dv/trim_props.sv
`timescale 1ns/10ps
module trim_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [11:0] core_a_offset,
	input wire logic [11:0] core_b_offset,
	input wire logic [4:0]  core_a_bank0_gain,
	input wire logic [4:0]  core_a_bank1_gain
);
	logic        wr;
	logic [2:0]  mode_r;
	logic [2:0]  mode_nxt;
	logic [33:0] outs;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shadow of the mode word, so routing can be predicted two edges after a write
	assign wr = psel & penable & pwrite & pready;
	assign outs = {core_a_offset, core_b_offset, core_a_bank0_gain, core_a_bank1_gain};
	always_comb mode_nxt = (wr && paddr == 16'h0d80) ? pwdata[2:0] : mode_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) mode_r <= 3'h0;
		else mode_r <= mode_nxt;
	// Stored value reaches its core one edge after the store
	single_off_a: assert property (wr && paddr == 16'h0d20 && mode_r == 3'h3
		|-> ##2 core_a_offset == $past(pwdata[11:0], 2)) else $error("core A offset");
	phase90_off_a: assert property (wr && paddr == 16'h0d28 && mode_r == 3'h7
		|-> ##2 core_a_offset == $past(pwdata[11:0], 2)) else $error("core A offset");
	b_in_a_a: assert property (wr && paddr == 16'h0d30 && mode_r[0] && !mode_r[2]
		|-> ##2 core_b_offset == $past(pwdata[11:0], 2)) else $error("core B offset");
	b_in_b_a: assert property (wr && paddr == 16'h0d38 && mode_r[0] && mode_r[2]
		|-> ##2 core_b_offset == $past(pwdata[11:0], 2)) else $error("core B offset");
	bank0_gain_a: assert property (wr && paddr == 16'h0d40 && mode_r[1:0] == 2'h1
		|-> ##2 core_a_bank0_gain == $past(pwdata[4:0], 2)) else $error("bank 0 gain");
	bank1_gain_a: assert property (wr && paddr == 16'h0d44 && mode_r[1:0] == 2'h1
		|-> ##2 core_a_bank1_gain == $past(pwdata[4:0], 2)) else $error("bank 1 gain");
	reset_zero_a: assert property ($rose(presetn)
		|-> outs == 34'h0_0000_0000) else $error("trims not zero after reset");
	gate_off_a: assert property (!$past(mode_r[0])
		|-> outs == 34'h0_0000_0000) else $error("trim used while calibration off");
endmodule
bind converter_trim_registers trim_props trim_props_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_a_offset, .core_b_offset,
	.core_a_bank0_gain, .core_a_bank1_gain);

// ### rtl/converter_trim_registers.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps

module converter_trim_registers (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [11:0] core_a_offset,
	output logic      [11:0] core_b_offset,
	output logic      [4:0]  core_a_bank0_gain,
	output logic      [4:0]  core_a_bank1_gain
);

	// ----------------------------------------------------------------
	// Storage and decode
	// ----------------------------------------------------------------
	logic [15:0] off_a_single_r, off_a_single_nxt;
	logic [15:0] off_a_p90b_r,   off_a_p90b_nxt;
	logic [15:0] off_b_ina_r,    off_b_ina_nxt;
	logic [15:0] off_b_inb_r,    off_b_inb_nxt;
	logic [7:0]  gain_a0_r,      gain_a0_nxt;
	logic [7:0]  gain_a1_r,      gain_a1_nxt;
	logic [2:0]  mode_r,         mode_nxt;
	logic [31:0] prdata_r,       prdata_nxt;
	logic [11:0] off_a_r,        off_a_nxt;
	logic [11:0] off_b_r,        off_b_nxt;
	logic [4:0]  g0_r,           g0_nxt;
	logic [4:0]  g1_r,           g1_nxt;
	logic        access;
	logic        wr_access;
	logic        hit;

	// Word index from byte address; low two bits must be zero
	function automatic logic [11:0] word_index(input logic [15:0] a);
		return a[13:2];
	endfunction

	// True for an aligned address that names one of the seven registers
	function automatic logic mapped(input logic [15:0] a);
		logic [11:0] i;
		i = word_index(a);
		return (a[1:0] == 2'b00) && (a[15:14] == 2'b00) &&
			(i == trim_pkg::core_a_single_input_a_offset_idx ||
			 i == trim_pkg::core_a_phase90_input_b_offset_idx ||
			 i == trim_pkg::core_b_input_a_offset_idx ||
			 i == trim_pkg::core_b_input_b_offset_idx ||
			 i == trim_pkg::core_a_bank0_dual_fine_gain_idx ||
			 i == trim_pkg::core_a_bank1_dual_fine_gain_idx ||
			 i == trim_pkg::trim_mode_idx);
	endfunction

	// Write strobe for one register; unmapped or misaligned writes are dropped
	function automatic logic wr_sel(
		input logic        acc,
		input logic [15:0] a,
		input logic [11:0] idx
	);
		return acc && mapped(a) && (word_index(a) == idx);
	endfunction

	// Zero wait states: access phase always completes at once
	assign access    = psel && penable;
	assign wr_access = access && pwrite;
	assign hit       = mapped(paddr);
	assign pready    = 1'b1;
	assign pslverr   = access && !hit;
	assign prdata    = prdata_r;
	assign core_a_offset     = off_a_r;
	assign core_b_offset     = off_b_r;
	assign core_a_bank0_gain = g0_r;
	assign core_a_bank1_gain = g1_r;

	// ----------------------------------------------------------------
	// Core A single-channel input A offset
	// ----------------------------------------------------------------
	// Reserved upper nibble is plain read/write storage
	always_comb begin
		off_a_single_nxt = off_a_single_r;
		if (wr_sel(wr_access, paddr, trim_pkg::core_a_single_input_a_offset_idx)) begin
			off_a_single_nxt = pwdata[15:0];
		end
	end

	// Zero until software loads the fuse defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_a_single_r <= trim_pkg::offset_reset;
		end else begin
			off_a_single_r <= off_a_single_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Core A 90-degree phase input B offset
	// ----------------------------------------------------------------
	// Own word, so the two core A phases never share a trim
	always_comb begin
		off_a_p90b_nxt = off_a_p90b_r;
		if (wr_sel(wr_access, paddr, trim_pkg::core_a_phase90_input_b_offset_idx)) begin
			off_a_p90b_nxt = pwdata[15:0];
		end
	end

	// Zero until software loads the fuse defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_a_p90b_r <= trim_pkg::offset_reset;
		end else begin
			off_a_p90b_r <= off_a_p90b_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Core B input A offset
	// ----------------------------------------------------------------
	// One word serves dual and single channel alike
	always_comb begin
		off_b_ina_nxt = off_b_ina_r;
		if (wr_sel(wr_access, paddr, trim_pkg::core_b_input_a_offset_idx)) begin
			off_b_ina_nxt = pwdata[15:0];
		end
	end

	// Zero until software loads the fuse defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_b_ina_r <= trim_pkg::offset_reset;
		end else begin
			off_b_ina_r <= off_b_ina_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Core B input B offset
	// ----------------------------------------------------------------
	// One word serves dual and single channel alike
	always_comb begin
		off_b_inb_nxt = off_b_inb_r;
		if (wr_sel(wr_access, paddr, trim_pkg::core_b_input_b_offset_idx)) begin
			off_b_inb_nxt = pwdata[15:0];
		end
	end

	// Zero until software loads the fuse defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_b_inb_r <= trim_pkg::offset_reset;
		end else begin
			off_b_inb_r <= off_b_inb_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Core A bank 0 dual-channel fine gain
	// ----------------------------------------------------------------
	// Reserved top three bits are stored but never routed
	always_comb begin
		gain_a0_nxt = gain_a0_r;
		if (wr_sel(wr_access, paddr, trim_pkg::core_a_bank0_dual_fine_gain_idx)) begin
			gain_a0_nxt = pwdata[7:0];
		end
	end

	// Zero until software loads the fuse defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_a0_r <= trim_pkg::gain_reset;
		end else begin
			gain_a0_r <= gain_a0_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Core A bank 1 dual-channel fine gain
	// ----------------------------------------------------------------
	// Same field placement as bank 0, next word
	always_comb begin
		gain_a1_nxt = gain_a1_r;
		if (wr_sel(wr_access, paddr, trim_pkg::core_a_bank1_dual_fine_gain_idx)) begin
			gain_a1_nxt = pwdata[7:0];
		end
	end

	// Zero until software loads the fuse defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_a1_r <= trim_pkg::gain_reset;
		end else begin
			gain_a1_r <= gain_a1_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Operating mode word
	// ----------------------------------------------------------------
	// Calibration enable, channel mode and sampled input in one word
	always_comb begin
		mode_nxt = mode_r;
		if (wr_sel(wr_access, paddr, trim_pkg::trim_mode_idx)) begin
			mode_nxt = pwdata[2:0];
		end
	end

	// Reset leaves calibration off, so no trim is applied
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= trim_pkg::mode_reset;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Captured at the setup edge so it stands for the whole access phase
	always_comb begin
		prdata_nxt = prdata_r;
		if (psel && !penable && !pwrite) begin
			prdata_nxt = 32'h0000_0000;
			if (hit) begin
				unique case (word_index(paddr))
					trim_pkg::core_a_single_input_a_offset_idx: prdata_nxt[15:0] = off_a_single_r;
					trim_pkg::core_a_phase90_input_b_offset_idx: prdata_nxt[15:0] = off_a_p90b_r;
					trim_pkg::core_b_input_a_offset_idx: prdata_nxt[15:0] = off_b_ina_r;
					trim_pkg::core_b_input_b_offset_idx: prdata_nxt[15:0] = off_b_inb_r;
					trim_pkg::core_a_bank0_dual_fine_gain_idx: prdata_nxt[7:0] = gain_a0_r;
					trim_pkg::core_a_bank1_dual_fine_gain_idx: prdata_nxt[7:0] = gain_a1_r;
					trim_pkg::trim_mode_idx: prdata_nxt[2:0] = mode_r;
					default: prdata_nxt = 32'h0000_0000;
				endcase
			end
		end
	end

	// Holds until the next read setup; writes leave it alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= trim_pkg::rdata_reset;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Trim routing to the cores
	// ----------------------------------------------------------------
	// Outside calibration every trim is held at zero so no stale value leaks
	always_comb begin
		off_a_nxt = 12'h000;
		off_b_nxt = 12'h000;
		g0_nxt    = 5'h00;
		g1_nxt    = 5'h00;
		if (mode_r[trim_pkg::mode_fg_bit]) begin
			if (mode_r[trim_pkg::mode_single_bit]) begin
				// Single channel: input B on core A uses the 90-degree phase
				if (mode_r[trim_pkg::mode_input_b_bit])
					off_a_nxt = off_a_p90b_r[11:0];
				else
					off_a_nxt = off_a_single_r[11:0];
			end else begin
				g0_nxt = gain_a0_r[4:0];
				g1_nxt = gain_a1_r[4:0];
			end
			if (mode_r[trim_pkg::mode_input_b_bit])
				off_b_nxt = off_b_inb_r[11:0];
			else
				off_b_nxt = off_b_ina_r[11:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_a_r <= trim_pkg::trim_off_reset;
			off_b_r <= trim_pkg::trim_off_reset;
			g0_r    <= trim_pkg::trim_gain_reset;
			g1_r    <= trim_pkg::trim_gain_reset;
		end else begin
			off_a_r <= off_a_nxt;
			off_b_r <= off_b_nxt;
			g0_r    <= g0_nxt;
			g1_r    <= g1_nxt;
		end
	end

endmodule

// ### rtl/trim_pkg.sv
package trim_pkg;

	// ----------------------------------------------------------------
	// Register indices (printed offsets; byte address is index times four)
	// ----------------------------------------------------------------
	localparam logic [11:0] core_a_single_input_a_offset_idx = 12'h0348;
	localparam logic [11:0] core_a_phase90_input_b_offset_idx = 12'h034a;
	localparam logic [11:0] core_b_input_a_offset_idx = 12'h034c;
	localparam logic [11:0] core_b_input_b_offset_idx = 12'h034e;
	localparam logic [11:0] core_a_bank0_dual_fine_gain_idx = 12'h0350;
	localparam logic [11:0] core_a_bank1_dual_fine_gain_idx = 12'h0351;
	localparam logic [11:0] trim_mode_idx = 12'h0360;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int offset_field_w = 12;
	localparam int offset_reg_w = 16;
	localparam int gain_field_w = 5;
	localparam int gain_reg_w = 8;
	localparam logic [15:0] offset_reset = 16'h0000;
	localparam logic [7:0] gain_reset = 8'h00;
	localparam logic [2:0] mode_reset = 3'h0;
	localparam logic [31:0] rdata_reset = 32'h0000_0000;
	localparam logic [11:0] trim_off_reset = 12'h000;
	localparam logic [4:0] trim_gain_reset = 5'h00;
	localparam int mode_fg_bit = 0;
	localparam int mode_single_bit = 1;
	localparam int mode_input_b_bit = 2;

endpackage
